// file: hdl/sei_device.sv
// sei_device: serial slave front end of a byte-wide serial eeprom, with
// status register, write latch, write protect and self-timed write cycle.
// assumes a mode-zero master on sck/cs_n/si/hold_n; sck runs only inside
// frames, cs_n high acts as the frame reset of the sck link state and output shifter, not the pending command.
`default_nettype none

module sei_device
  import sei_pkg::*;
#(
  parameter int WRITE_CYCLES = WC_CYCLES
) (
  // core clock, reset and enable
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              clk_en,
  // serial link pins
  input  wire logic              sck,
  input  wire logic              cs_n,
  input  wire logic              si,
  input  wire logic              hold_n,
  input  wire logic              wp_n,
  output logic                   so_out,
  output logic                   so_oe,
  // state seen by the array side
  output logic                   write_busy,
  output logic                   write_latch,
  output logic [1:0]             block_protect,
  output logic                   protect_pin_enable,
  output logic                   array_write_start,
  output logic [15:0]            array_write_addr
);

  localparam int             WC_W    = $clog2(WRITE_CYCLES + 1);
  localparam logic [WC_W-1:0] WC_LAST = WC_W'(WRITE_CYCLES - 1);

  // masked opcode to link state; anything else is illegal
  function automatic sei_link_state_t op_state(input logic [7:0] op);
    logic [7:0] m;
    m = op & OPC_MASK;
    unique case (m)
      OPC_SET_LATCH: op_state = LK_DONE;
      OPC_CLR_LATCH: op_state = LK_DONE;
      OPC_STAT_RD:   op_state = LK_STATUS_RD;
      OPC_STAT_WR:   op_state = LK_STATUS_WR;
      OPC_ARRAY_RD:  op_state = LK_ARRAY_RD;
      OPC_ARRAY_WR:  op_state = LK_ARRAY_WR;
      default:       op_state = LK_INVALID;
    endcase
  endfunction

  // masked opcode to the command handed to the core
  function automatic sei_cmd_t op_cmd(input logic [7:0] op);
    logic [7:0] m;
    m = op & OPC_MASK;
    unique case (m)
      OPC_SET_LATCH: op_cmd = CMD_SET_LATCH;
      OPC_CLR_LATCH: op_cmd = CMD_CLR_LATCH;
      OPC_STAT_WR:   op_cmd = CMD_STATUS_WR;
      OPC_ARRAY_WR:  op_cmd = CMD_ARRAY_WR;
      default:       op_cmd = CMD_NONE;
    endcase
  endfunction

  // true when the address lies in the block-protected region
  function automatic logic addr_locked(input logic [15:0] a,
                                       input logic [1:0]  bp);
    logic [1:0] top;
    top = a[ADDR_W-1 -: 2];
    unique case (bp)
      2'h0: addr_locked = 1'b0;
      2'h1: addr_locked = (top == 2'h3);
      2'h2: addr_locked = top[1];
      2'h3: addr_locked = 1'b1;
    endcase
  endfunction

  // link-side frame state
  sei_link_state_t link_state_reg, link_state_next;
  logic [5:0]      bit_cnt_reg, bit_cnt_next;
  logic [7:0]      shift_reg, shift_next;
  logic [15:0]     addr_reg, addr_next;
  logic [7:0]      rx_byte;
  logic            link_step;
  // command left for the core at the end of a frame
  sei_cmd_t        cmd_reg, cmd_next;
  logic            cmd_ok_reg, cmd_ok_next;
  logic [7:0]      cmd_data_reg, cmd_data_next;
  logic [15:0]     cmd_addr_reg, cmd_addr_next;
  // output shifter on the falling edge
  logic [2:0]      out_idx_reg, out_idx_next;
  logic            so_reg, so_next;
  logic            so_en_reg, so_en_next;
  // core-side state
  logic            cs_s1, cs_s2, cs_s3;
  logic            wp_s1, wp_s2, wp_s3;
  sei_core_state_t core_state_reg, core_state_next;
  logic [WC_W-1:0] wc_cnt_reg, wc_cnt_next;
  logic            latch_reg, latch_next;
  logic [1:0]      bp_reg, bp_next, new_bp_reg, new_bp_next;
  logic            pin_en_reg, pin_en_next, new_pin_en_reg, new_pin_en_next;
  logic            commit_reg, commit_next;
  logic            wp_fell_reg, wp_fell_next;
  logic [7:0]      status_word_reg, status_word_next;
  logic            start_reg, start_next;
  logic [15:0]     start_addr_reg, start_addr_next;
  logic            cs_rise, wp_fall, hw_protect;

  // bit capture on rising sck; a paused or refused frame takes no bits
  always_comb begin
    rx_byte         = {shift_reg[6:0], si};
    link_step       = hold_n && (link_state_reg != LK_INVALID);
    link_state_next = link_state_reg;
    bit_cnt_next    = bit_cnt_reg;
    shift_next      = shift_reg;
    addr_next       = addr_reg;
    if (link_step) begin
      shift_next   = rx_byte;
      // data bytes wrap the count so each byte end looks the same
      bit_cnt_next = (bit_cnt_reg == BIT_DATA_LAST) ? BIT_DATA_WRAP
                                                    : bit_cnt_reg + 6'h01;
      if (bit_cnt_reg > BIT_OPC_LAST && bit_cnt_reg <= BIT_ADDR_LAST) begin
        addr_next = {addr_reg[14:0], si};
      end
      if (link_state_reg == LK_OPCODE && bit_cnt_reg == BIT_OPC_LAST) begin
        link_state_next = op_state(rx_byte);
      end
    end
  end

  // frame logic is cleared whenever the chip is deselected
  always_ff @(posedge sck or posedge cs_n) begin // sck is input only
    if (cs_n) begin
      link_state_reg <= LK_OPCODE;
      bit_cnt_reg    <= 6'h00;
      shift_reg      <= 8'h00;
      addr_reg       <= 16'h0000;
    end else begin                               // rising edge sample
      link_state_reg <= link_state_next;
      bit_cnt_reg    <= bit_cnt_next;
      shift_reg      <= shift_next;
      addr_reg       <= addr_next;
    end
  end

  // pending command: armed only on a whole instruction; extra bits void a status write, and an array write unless they end a byte, but not a latch set or clear
  always_comb begin
    cmd_next      = cmd_reg;
    cmd_ok_next   = cmd_ok_reg;
    cmd_data_next = cmd_data_reg;
    cmd_addr_next = cmd_addr_reg;
    if (link_step) begin
      if (bit_cnt_reg == 6'h00) begin
        cmd_ok_next = 1'b0;
      end
      unique case (link_state_reg)
        LK_OPCODE: begin
          if (bit_cnt_reg == BIT_OPC_LAST) begin
            cmd_next    = op_cmd(rx_byte);
            cmd_ok_next = (op_cmd(rx_byte) == CMD_SET_LATCH) ||
                          (op_cmd(rx_byte) == CMD_CLR_LATCH);
          end
        end
        LK_STATUS_WR: begin
          cmd_ok_next = (bit_cnt_reg == BIT_STWR_LAST);
          if (bit_cnt_reg == BIT_STWR_LAST) begin
            cmd_data_next = rx_byte;
          end
        end
        LK_ARRAY_WR: begin
          cmd_ok_next = (bit_cnt_reg == BIT_DATA_LAST);
          if (bit_cnt_reg == BIT_DATA_LAST) begin
            cmd_addr_next = addr_reg;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // kept across deselect so the core can read it after the frame ends
  always_ff @(posedge sck or negedge reset_n) begin
    if (!reset_n) begin
      cmd_reg      <= CMD_NONE;
      cmd_ok_reg   <= 1'b0;
      cmd_data_reg <= 8'h00;
      cmd_addr_reg <= 16'h0000;
    end else begin
      cmd_reg      <= cmd_next;
      cmd_ok_reg   <= cmd_ok_next;
      cmd_data_reg <= cmd_data_next;
      cmd_addr_reg <= cmd_addr_next;
    end
  end

  // status shifts out msb first after falling edges, repeating each byte
  always_comb begin
    out_idx_next = out_idx_reg;
    so_next      = so_reg;
    so_en_next   = so_en_reg;
    if (hold_n && link_state_reg == LK_STATUS_RD) begin
      so_next      = status_word_reg[3'h7 - out_idx_reg];
      out_idx_next = out_idx_reg + 3'h1;
      so_en_next   = 1'b1;
    end
  end

  // hold_n is only stable at sck edges because it moves while sck is low
  always_ff @(negedge sck or posedge cs_n) begin
    if (cs_n) begin
      out_idx_reg <= 3'h0;
      so_reg      <= 1'b0;
      so_en_reg   <= 1'b0;
    end else begin
      out_idx_reg <= out_idx_next;
      so_reg      <= so_next;
      so_en_reg   <= so_en_next;
    end
  end

  // output floats when deselected, paused, or never enabled by a read
  assign so_oe  = so_en_reg & ~cs_n & hold_n;
  assign so_out = so_reg;

  // pin synchronisers into the core clock
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_s3 <= 1'b1;
      wp_s1 <= 1'b1;
      wp_s2 <= 1'b1;
      wp_s3 <= 1'b1;
    end else if (clk_en) begin
      cs_s1 <= cs_n;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
      wp_s1 <= wp_n;
      wp_s2 <= wp_s1;
      wp_s3 <= wp_s2;
    end
  end

  // core: acts on the finished frame at deselect, runs the write cycle
  always_comb begin
    cs_rise    = cs_s2 & ~cs_s3;
    wp_fall    = ~wp_s2 & wp_s3;
    // a fall seen at any time during the frame still counts at its end
    hw_protect = pin_en_reg & (~wp_s2 | wp_fell_reg);
    core_state_next  = core_state_reg;
    wc_cnt_next      = wc_cnt_reg;
    latch_next       = latch_reg;
    bp_next          = bp_reg;
    pin_en_next      = pin_en_reg;
    new_bp_next      = new_bp_reg;
    new_pin_en_next  = new_pin_en_reg;
    commit_next      = commit_reg;
    wp_fell_next     = wp_fell_reg;
    start_next       = 1'b0;
    start_addr_next  = start_addr_reg;
    status_word_next = status_word_reg;
    if (cs_rise) begin
      wp_fell_next = 1'b0;
    end
    if (!cs_s2 && wp_fall) begin
      wp_fell_next = 1'b1;
    end
    unique case (core_state_reg)
      CORE_IDLE: begin
        if (cs_rise && cmd_ok_reg) begin
          unique case (cmd_reg)
            CMD_SET_LATCH: latch_next = 1'b1;
            CMD_CLR_LATCH: latch_next = 1'b0;
            CMD_STATUS_WR: begin
              // no latch, no write: relies on the master's latch set
              if (latch_reg && !hw_protect) begin
                core_state_next = CORE_WRITE;
                wc_cnt_next     = '0;
                new_bp_next     = cmd_data_reg[ST_BP_HIGH:ST_BP_LOW];
                new_pin_en_next = cmd_data_reg[ST_PIN_EN];
                commit_next     = 1'b1;
              end
            end
            CMD_ARRAY_WR: begin
              if (latch_reg && !addr_locked(cmd_addr_reg, bp_reg)) begin
                core_state_next = CORE_WRITE;
                wc_cnt_next     = '0;
                commit_next     = 1'b0;
                start_next      = 1'b1;
                start_addr_next = cmd_addr_reg;
              end
            end
            default: begin
            end
          endcase
        end
      end
      CORE_WRITE: begin
        if (wc_cnt_reg == WC_LAST) begin
          core_state_next = CORE_IDLE;
          latch_next      = 1'b0;
          commit_next     = 1'b0;
          if (commit_reg) begin
            bp_next     = new_bp_reg;
            pin_en_next = new_pin_en_reg;
          end
        end else begin
          wc_cnt_next = wc_cnt_reg + 1'b1;
        end
      end
    endcase
    // the word read by the sck side only moves while deselected, so it
    // is steady for the whole of a status read; a read held open across
    // the end of a cycle keeps showing busy until the next frame
    if (cs_s2) begin
      status_word_next = (core_state_reg == CORE_WRITE) ? ST_BUSY_WORD
        : {pin_en_reg, 3'h0, bp_reg, latch_reg, 1'b0};
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      core_state_reg  <= CORE_IDLE;
      wc_cnt_reg      <= '0;
      latch_reg       <= 1'b0;
      bp_reg          <= BP_RESET;
      pin_en_reg      <= PIN_EN_RESET;
      new_bp_reg      <= BP_RESET;
      new_pin_en_reg  <= PIN_EN_RESET;
      commit_reg      <= 1'b0;
      wp_fell_reg     <= 1'b0;
      start_reg       <= 1'b0;
      start_addr_reg  <= 16'h0000;
      status_word_reg <= ST_RESET;
    end else if (clk_en) begin
      core_state_reg  <= core_state_next;
      wc_cnt_reg      <= wc_cnt_next;
      latch_reg       <= latch_next;
      bp_reg          <= bp_next;
      pin_en_reg      <= pin_en_next;
      new_bp_reg      <= new_bp_next;
      new_pin_en_reg  <= new_pin_en_next;
      commit_reg      <= commit_next;
      wp_fell_reg     <= wp_fell_next;
      start_reg       <= start_next;
      start_addr_reg  <= start_addr_next;
      status_word_reg <= status_word_next;
    end
  end

  assign write_busy         = (core_state_reg == CORE_WRITE);
  assign write_latch        = latch_reg;
  assign block_protect      = bp_reg;
  assign protect_pin_enable = pin_en_reg;
  assign array_write_start  = start_reg;
  assign array_write_addr   = start_addr_reg;

  // checks in the core domain
  sequence s_frame_cmd(sei_cmd_t c);
    clk_en && cs_rise && cmd_ok_reg && cmd_reg == c &&
    core_state_reg == CORE_IDLE;
  endsequence

  property p_set_latch;
    @(posedge clk) disable iff (!reset_n)
    s_frame_cmd(CMD_SET_LATCH) |=> latch_reg;
  endproperty
  a_set_latch: assert property (p_set_latch)
    else $error("latch set command did not set the latch");

  property p_clear_latch;
    @(posedge clk) disable iff (!reset_n)
    s_frame_cmd(CMD_CLR_LATCH) |=> !latch_reg && !write_busy;
  endproperty
  a_clear_latch: assert property (p_clear_latch)
    else $error("latch clear command left programming enabled");

  property p_hw_refuse;
    @(posedge clk) disable iff (!reset_n)
    (s_frame_cmd(CMD_STATUS_WR) and (pin_en_reg && !wp_s2))
      |=> core_state_reg == CORE_IDLE ##1 $stable(bp_reg);
  endproperty
  a_hw_refuse: assert property (p_hw_refuse)
    else $error("status write accepted while pin protected");

  property p_busy_word;
    @(posedge clk) disable iff (!reset_n)
    (clk_en && cs_s2 && core_state_reg == CORE_WRITE)
      |=> status_word_reg == ST_BUSY_WORD;
  endproperty
  a_busy_word: assert property (p_busy_word)
    else $error("status word not all ones during write cycle");

  property p_ready_word;
    @(posedge clk) disable iff (!reset_n)
    (clk_en && cs_s2 && core_state_reg == CORE_IDLE)
      |=> status_word_reg[6:4] == 3'h0 && !status_word_reg[0] &&
          status_word_reg[1] == $past(latch_reg);
  endproperty
  a_ready_word: assert property (p_ready_word)
    else $error("idle status word shows wrong busy, latch or unused bits");

  sequence s_cycle_end;
    clk_en && core_state_reg == CORE_WRITE && wc_cnt_reg == WC_LAST;
  endsequence

  property p_cycle_end;
    @(posedge clk) disable iff (!reset_n)
    s_cycle_end |=> core_state_reg == CORE_IDLE && !latch_reg;
  endproperty
  a_cycle_end: assert property (p_cycle_end)
    else $error("write cycle end did not clear latch and busy");

  property p_cycle_bound;
    @(posedge clk) disable iff (!reset_n)
    core_state_reg == CORE_WRITE |-> wc_cnt_reg <= WC_LAST;
  endproperty
  a_cycle_bound: assert property (p_cycle_bound)
    else $error("write cycle ran past its maximum length");

  property p_busy_ignores;
    @(posedge clk) disable iff (!reset_n)
    (core_state_reg == CORE_WRITE && !(wc_cnt_reg == WC_LAST))
      |=> $stable(latch_reg) && $stable(bp_reg) && $stable(pin_en_reg);
  endproperty
  a_busy_ignores: assert property (p_busy_ignores)
    else $error("state changed by an instruction during write cycle");

  property p_protect_only_by_write;
    @(posedge clk) disable iff (!reset_n)
    ($changed(bp_reg) || $changed(pin_en_reg))
      |-> $past(core_state_reg) == CORE_WRITE && $past(commit_reg);
  endproperty
  a_protect_only_by_write: assert property (p_protect_only_by_write)
    else $error("protect bits changed outside a status write cycle");

  // checks in the link domain, reset by deselect
  property p_bad_opcode_quiet;
    @(posedge sck) disable iff (cs_n)
    (link_state_reg == LK_OPCODE && bit_cnt_reg == BIT_OPC_LAST && hold_n &&
     op_state(rx_byte) == LK_INVALID) |=> !so_oe ##1 !so_oe;
  endproperty
  a_bad_opcode_quiet: assert property (p_bad_opcode_quiet)
    else $error("output driven after an unknown opcode");

  property p_pause_freeze;
    @(posedge sck) disable iff (cs_n)
    !hold_n |=> $stable(bit_cnt_reg) && $stable(shift_reg);
  endproperty
  a_pause_freeze: assert property (p_pause_freeze)
    else $error("serial sequence moved while paused");

endmodule

`default_nettype wire

// file: pkg/sei_pkg.sv
// sei_pkg: opcodes, status layout, bit counts, timing and state types for
// the serial eeprom command interface.
// assumes one 100 MHz core clock and a mode-zero serial master.
`default_nettype none

package sei_pkg;

  // opcodes; bit 3 is masked off before comparing
  localparam logic [7:0] OPC_MASK      = 8'hf7;
  localparam logic [7:0] OPC_SET_LATCH = 8'h06;
  localparam logic [7:0] OPC_CLR_LATCH = 8'h04;
  localparam logic [7:0] OPC_STAT_RD   = 8'h05;
  localparam logic [7:0] OPC_STAT_WR   = 8'h01;
  localparam logic [7:0] OPC_ARRAY_RD  = 8'h03;
  localparam logic [7:0] OPC_ARRAY_WR  = 8'h02;

  // status byte field positions and values
  localparam int         ST_PIN_EN    = 7;
  localparam int         ST_BP_HIGH   = 3;
  localparam int         ST_BP_LOW    = 2;
  localparam logic [7:0] ST_BUSY_WORD = 8'hff;
  localparam logic [7:0] ST_RESET     = 8'h00;
  localparam logic [1:0] BP_RESET     = 2'h0;
  localparam logic       PIN_EN_RESET = 1'b0;

  // array address width and serial bit positions within a frame
  localparam int         ADDR_W        = 15;
  localparam logic [5:0] BIT_OPC_LAST  = 6'h07;
  localparam logic [5:0] BIT_STWR_LAST = 6'h0f;
  localparam logic [5:0] BIT_ADDR_LAST = 6'h17;
  localparam logic [5:0] BIT_DATA_LAST = 6'h1f;
  localparam logic [5:0] BIT_DATA_WRAP = 6'h18;

  // self-timed write cycle, maximum time in ms and derived core cycles
  localparam int T_WC_MS   = 5;
  localparam int CLK_MHZ   = 100;
  localparam int WC_CYCLES = T_WC_MS * CLK_MHZ * 1000;

  typedef enum logic [2:0] {
    LK_OPCODE    = 3'b000,
    LK_STATUS_RD = 3'b001,
    LK_STATUS_WR = 3'b011,
    LK_ARRAY_WR  = 3'b010,
    LK_ARRAY_RD  = 3'b110,
    LK_DONE      = 3'b111,
    LK_INVALID   = 3'b101
  } sei_link_state_t;

  typedef enum logic [2:0] {
    CMD_NONE      = 3'h0,
    CMD_SET_LATCH = 3'h1,
    CMD_CLR_LATCH = 3'h2,
    CMD_STATUS_WR = 3'h3,
    CMD_ARRAY_WR  = 3'h4
  } sei_cmd_t;

  typedef enum logic {
    CORE_IDLE  = 1'b0,
    CORE_WRITE = 1'b1
  } sei_core_state_t;

endpackage

`default_nettype wire

// file: testbench/sei_spi_master.sv
// sei_spi_master: mode-zero serial master model for the eeprom front end.
// assumes the device samples si on rising sck and drives so after falling.
`default_nettype none
module sei_spi_master (
  // link pins
  output var logic sck,
  output var logic cs_n,
  output var logic si,
  output var logic hold_n,
  input  wire logic so_out,
  input  wire logic so_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic oe_in_hold;  // any output enable seen while paused

  // sck idles low, so it only runs inside frames
  initial begin
    sck = 1'b0;
    cs_n <= 1'b1;  // nba so the frame logic sees this rising edge
    si = 1'b0;
    hold_n = 1'b1;
    oe_in_hold = 1'b0;
  end

  // one frame of n bits, msb first, with a pause after bit hp when hp < n
  task automatic xfer(input logic [31:0] tx, input int n, input int hp,
                      output logic [31:0] rx);
    rx = '0;
    #7 cs_n = 1'b0;  // odd offset keeps sck unrelated to clk
    #100;
    for (int i = 0; i < n; i++) begin
      si = tx[n-1-i];
      #16 sck = 1'b1;
      rx = {rx[30:0], so_oe ? so_out : 1'bx};
      #16 sck = 1'b0;
      if (i == hp) begin
        #4 hold_n = 1'b0;
        repeat (2) begin
          #16 sck = 1'b1;  // clock may run during the pause
          si = ~si;
          oe_in_hold = oe_in_hold | so_oe;
          #16 sck = 1'b0;
        end
        #4 hold_n = 1'b1;  // off the falling edge, sck still low
      end
    end
    #100 cs_n = 1'b1;
    si = ~si;  // a released line must not show its last value
    #150;
  endtask
endmodule
`default_nettype wire

// file: testbench/sei_device_tb_top.sv
// sei_device_tb_top: self-checking bench for the eeprom command front end.
// assumes a short write cycle through WRITE_CYCLES and the master model.
`default_nettype none
module sei_device_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk, reset_n, clk_en, wp_n;
  wire logic   sck, cs_n, si, hold_n;
  logic        so_out, so_oe, write_busy, write_latch;
  logic [1:0]  block_protect;
  logic        protect_pin_enable, array_write_start;
  logic [15:0] array_write_addr;
  logic [31:0] rx;
  int          fail_count = 0, checked = 0, starts = 0;

  sei_device #(.WRITE_CYCLES(200)) uut (.clk(clk), .reset_n(reset_n),
    .clk_en(clk_en), .sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n),
    .wp_n(wp_n), .so_out(so_out), .so_oe(so_oe), .write_busy(write_busy),
    .write_latch(write_latch), .block_protect(block_protect),
    .protect_pin_enable(protect_pin_enable),
    .array_write_start(array_write_start),
    .array_write_addr(array_write_addr));
  sei_spi_master bfm (.sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n),
    .so_out(so_out), .so_oe(so_oe));

  // core clock and a count of array write starts
  initial clk = 1'b0;
  always #5 clk = ~clk;
  always @(posedge clk) if (array_write_start === 1'b1) starts++;

  task automatic chk(input logic [15:0] got, exp, input string m);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic conclude;
    if (fail_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic send(input logic [31:0] tx, input int n);
    bfm.xfer(tx, n, 99, rx);
  endtask
  task automatic rd_st(input logic [7:0] exp);
    bfm.xfer(32'h0500, 16, 99, rx);
    chk(rx[7:0], exp, "status byte");
  endtask
  task automatic wait_idle;
    for (int k = 0; k < 400 && write_busy !== 1'b0; k++) @(negedge clk);
    chk(write_busy, 1'b0, "write cycle end");
  endtask
  task automatic t_latch;
    chk(so_oe, 1'b0, "deselected output");
    rd_st(8'h00);
    send(32'h0e, 8);
    chk(write_latch, 1'b1, "latch set");
    bfm.xfer(32'h0d00, 16, 99, rx);
    chk(rx[7:0], 8'h02, "latch bit");
    @(negedge clk) wp_n = 1'b0;
    send(32'h0c, 8);
    chk(write_latch, 1'b0, "latch clear");
    @(negedge clk) wp_n = 1'b1;
  endtask
  task automatic t_stwr;
    send(32'h06, 8);
    send(32'h018c, 16);
    chk(write_busy, 1'b1, "busy");
    rd_st(8'hff);
    wait_idle();
    chk(write_latch, 1'b0, "latch after cycle");
    chk({protect_pin_enable, block_protect}, 3'h7, "new bits");
    rd_st(8'h8c);
  endtask
  task automatic t_protect;
    @(negedge clk) wp_n = 1'b0;
    send(32'h06, 8);
    send(32'h0100, 16);
    chk(write_busy, 1'b0, "pin refuses");
    @(negedge clk) wp_n = 1'b1;
    fork
      send(32'h0100, 16);
      begin #400 @(negedge clk) wp_n = 1'b0; end
    join
    chk({write_busy, block_protect}, 3'h3, "aborted");
    @(negedge clk) wp_n = 1'b1;
    send(32'h0100, 16);
    wait_idle();
    chk({protect_pin_enable, block_protect}, 3'h0, "pin high");
    @(negedge clk) wp_n = 1'b0;
    send(32'h06, 8);
    send(32'h0104, 16);
    wait_idle();
    chk(block_protect, 2'h1, "pin ignored");
    @(negedge clk) wp_n = 1'b1;
  endtask
  task automatic t_array;
    send(32'h06, 8);
    send(32'h02001055, 32);
    chk(starts, 1, "array start");
    chk(array_write_addr, 16'h0010, "array addr");
    send(32'h04, 8);
    chk(write_latch, 1'b1, "ignored while busy");
    wait_idle();
    send(32'h06, 8);
    send(32'h02700055, 32);
    chk({starts, write_busy}, 2'h2, "protected quarter");
    send(32'h04, 8);
  endtask
  task automatic t_odd;
    send(32'h40050000, 32);
    chk(rx[15:0], 16'hxxxx, "unknown opcode");
    send(32'h07050000, 32);
    chk(rx[15:0], 16'hxxxx, "unknown low code");
    send(32'h03000000, 32);
    chk(rx[15:0], 16'hxxxx, "array read undriven");
    bfm.xfer(32'h0500, 16, 10, rx);
    chk(rx[7:0], 8'h04, "paused read");
    chk(bfm.oe_in_hold, 1'b0, "floats while paused");
  endtask

  // cut a hang short
  initial begin
    #100us;
    fail_count++;
    conclude();
  end
  // reset, then the scenarios in order
  initial begin
    reset_n <= 1'b0;  // nba so the async reset edge is not missed
    clk_en = 1'b1;
    wp_n = 1'b1;
    repeat (4) @(negedge clk);
    reset_n = 1'b1;
    repeat (3) @(negedge clk);
    t_latch();
    t_stwr();
    t_protect();
    t_array();
    t_odd();
    conclude();
  end
endmodule
`default_nettype wire
